// >>> logic/pbx_pkg.sv
package pbx_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] PBX_ADDR_IRQ_ENABLE  = 8'h31;
	localparam logic [7:0] PBX_ADDR_FUNC_MODE   = 8'h32;
	localparam logic [7:0] PBX_ADDR_IRQ_STATUS  = 8'h3C;
	localparam logic [7:0] PBX_ADDR_IRQ_MASK    = 8'h3D;
	localparam logic [7:0] PBX_ADDR_PIN_LEVEL   = 8'h3E;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PBX_BIT_PIN0_FUNC   = 0;
	localparam int PBX_BIT_PIN1_FUNC   = 1;
	localparam int PBX_BIT_SAMPLE_RATE = 3;
	localparam int PBX_BIT_EVT_CHANGE  = 0;

	// ----------------------------------------
	// reset values and write mask
	// ----------------------------------------
	localparam logic [3:0] PBX_RST_FUNC_MODE  = 4'h0;
	localparam logic [3:0] PBX_RST_IRQ_ENABLE = 4'h0;
	localparam logic [3:0] PBX_FUNC_MODE_MASK = 4'hB;
	localparam logic [3:0] PBX_RST_STATUS     = 4'h0;
	localparam logic [3:0] PBX_RST_MASK       = 4'h0;

	// ----------------------------------------
	// sampling states
	// ----------------------------------------
	typedef enum logic [1:0] {
		PBX_ST_IDLE   = 2'b01,
		PBX_ST_ACTIVE = 2'b10
	} pbx_state_e;

endpackage

// >>> logic/pbx_port_b.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps

module pbx_port_b
	import pbx_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic [7:0] reg_addr,
	input  wire logic [3:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [3:0] reg_rdata,
	input  wire logic [3:0] pin_in,
	input  wire logic [3:0] pin_direction,
	input  wire logic [3:0] port_data_out,
	input  wire logic [3:0] pin_input_idle_high,
	input  wire logic       tbc_128hz,
	input  wire logic       tbc_4khz,
	input  wire logic       timer0_overflow_flag,
	input  wire logic       timer1_overflow_flag,
	output logic      [3:0] pin_out,
	output logic      [3:0] pin_oe,
	output logic            timer0_capture_in,
	output logic            timer1_capture_in,
	output logic            timer0_2_ext_clock,
	output logic            timer1_3_ext_clock,
	output logic            ext_irq_request,
	output logic            ext_irq_pending_flag,
	input  wire logic       ext_irq_accept,
	output logic            ext_irq_vector_valid,
	output logic [15:0]     ext_irq_vector,
	output logic            irq
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// per pin: high when the pin sits away from its idle level and is enabled
	function automatic logic [3:0] away_from_idle(input logic [3:0] lvl, input logic [3:0] idle_hi,
		input logic [3:0] en);
		away_from_idle = (lvl ^ idle_hi) & en;
	endfunction

	localparam logic [15:0] PBX_VECTOR = 16'h0014;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [3:0] func_mode_q;
	logic [3:0] irq_enable_q;
	logic [3:0] status_q;
	logic [3:0] mask_q;
	logic       wr_func;
	logic       wr_en;
	logic       wr_stat;
	logic       wr_mask;

	assign wr_func = reg_write && (reg_addr == PBX_ADDR_FUNC_MODE);
	assign wr_en   = reg_write && (reg_addr == PBX_ADDR_IRQ_ENABLE);
	assign wr_stat = reg_write && (reg_addr == PBX_ADDR_IRQ_STATUS);
	assign wr_mask = reg_write && (reg_addr == PBX_ADDR_IRQ_MASK);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			func_mode_q <= PBX_RST_FUNC_MODE;
		end else if (wr_func) begin
			func_mode_q <= reg_wdata & PBX_FUNC_MODE_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			irq_enable_q <= PBX_RST_IRQ_ENABLE;
		end else if (wr_en) begin
			irq_enable_q <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			mask_q <= PBX_RST_MASK;
		end else if (wr_mask) begin
			mask_q <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			reg_rdata <= 4'h0;
		end else if (reg_read) begin
			case (reg_addr)
				PBX_ADDR_FUNC_MODE:  reg_rdata <= func_mode_q;
				PBX_ADDR_IRQ_ENABLE: reg_rdata <= irq_enable_q;
				PBX_ADDR_IRQ_STATUS: reg_rdata <= status_q;
				PBX_ADDR_IRQ_MASK:   reg_rdata <= mask_q;
				PBX_ADDR_PIN_LEVEL:  reg_rdata <= pin_in;
				default:             reg_rdata <= 4'h0;
			endcase
		end else begin
			reg_rdata <= 4'h0;
		end
	end

	// ----------------------------------------
	// pin functions
	// ----------------------------------------
	always_comb begin
		pin_out = port_data_out;
		pin_oe  = pin_direction;
		if (func_mode_q[PBX_BIT_PIN0_FUNC]) begin
			pin_out[0] = timer0_overflow_flag;
			pin_oe[0]  = 1'b1;
		end
		if (func_mode_q[PBX_BIT_PIN1_FUNC]) begin
			pin_out[1] = timer1_overflow_flag;
			pin_oe[1]  = 1'b1;
		end
	end

	assign timer0_capture_in  = pin_in[0];
	assign timer1_capture_in  = pin_in[1];
	assign timer0_2_ext_clock = pin_in[2];
	assign timer1_3_ext_clock = pin_in[3];

	// ----------------------------------------
	// sampling
	// ----------------------------------------
	logic sample_clk;
	logic sample_clk_q;
	logic sample_tick;

	assign sample_clk = func_mode_q[PBX_BIT_SAMPLE_RATE] ? tbc_4khz : tbc_128hz;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sample_clk_q <= 1'b0;
		end else begin
			sample_clk_q <= sample_clk;
		end
	end

	// a rate switch may fake one falling edge; harmless, it only adds a sample
	assign sample_tick = sample_clk_q && !sample_clk;

	// ----------------------------------------
	// change detector
	// ----------------------------------------
	pbx_state_e state_q;
	logic       any_away;
	logic       change_evt;

	assign any_away = |away_from_idle(pin_in, pin_input_idle_high, irq_enable_q);

	always_comb begin
		change_evt = 1'b0;
		if (sample_tick) begin
			case (state_q)
				PBX_ST_IDLE:   change_evt = any_away;
				PBX_ST_ACTIVE: change_evt = !any_away;
				default:       change_evt = 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_q <= PBX_ST_IDLE;
		end else if (sample_tick) begin
			state_q <= any_away ? PBX_ST_ACTIVE : PBX_ST_IDLE;
		end
	end

	// request pulse, registered on the tick: well inside one sampling period
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ext_irq_request <= 1'b0;
		end else begin
			ext_irq_request <= change_evt;
		end
	end

	// pending flag holds until the interrupt is accepted; new set wins
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ext_irq_pending_flag <= 1'b0;
		end else if (change_evt) begin
			ext_irq_pending_flag <= 1'b1;
		end else if (ext_irq_accept) begin
			ext_irq_pending_flag <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ext_irq_vector_valid <= 1'b0;
			ext_irq_vector       <= 16'h0000;
		end else begin
			ext_irq_vector_valid <= ext_irq_accept && ext_irq_pending_flag;
			ext_irq_vector       <= PBX_VECTOR;
		end
	end

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			status_q <= PBX_RST_STATUS;
		end else begin
			status_q[PBX_BIT_EVT_CHANGE] <= change_evt ||
				(status_q[PBX_BIT_EVT_CHANGE] && !(wr_stat && reg_wdata[PBX_BIT_EVT_CHANGE]));
			status_q[3:1] <= 3'h0;
		end
	end

	assign irq = |(status_q & mask_q);

endmodule

// >>> testbench/pbx_chk.sv
`timescale 1ns/1ps
module pbx_chk(
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic [3:0]  pin_in,
	input wire logic [3:0]  pin_direction,
	input wire logic [3:0]  pin_oe,
	input wire logic [3:0]  pin_out,
	input wire logic        timer0_overflow_flag,
	input wire logic        timer1_overflow_flag,
	input wire logic        timer0_capture_in,
	input wire logic        timer1_capture_in,
	input wire logic        timer0_2_ext_clock,
	input wire logic        timer1_3_ext_clock,
	input wire logic        tbc_128hz,
	input wire logic        tbc_4khz,
	input wire logic        ext_irq_request,
	input wire logic        ext_irq_pending_flag,
	input wire logic        ext_irq_vector_valid,
	input wire logic [15:0] ext_irq_vector
);
	// ----------------
	// checks
	// ----------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	cap_route_a: assert property ({timer1_capture_in, timer0_capture_in} == pin_in[1:0])
		else $error("capture routing wrong");
	clk_route_a: assert property ({timer1_3_ext_clock, timer0_2_ext_clock} == pin_in[3:2])
		else $error("ext clock routing wrong");
	pin0_func_a: assert property (pin_oe[0] == pin_direction[0] || (pin_oe[0] && pin_out[0] == timer0_overflow_flag))
		else $error("pin0 function wrong");
	pin1_func_a: assert property (pin_oe[1] == pin_direction[1] || (pin_oe[1] && pin_out[1] == timer1_overflow_flag))
		else $error("pin1 function wrong");
	req_pulse_a: assert property (ext_irq_request |=> !ext_irq_request)
		else $error("request longer than one cycle");
	req_flag_a: assert property (ext_irq_request |-> ext_irq_pending_flag)
		else $error("request without pending flag");
	req_tick_a: assert property (ext_irq_request |-> ($past(tbc_128hz, 2) && !$past(tbc_128hz))
		|| ($past(tbc_4khz, 2) && !$past(tbc_4khz)))
		else $error("request off a tap falling edge");
	vec_addr_a: assert property (ext_irq_vector_valid |-> ext_irq_vector == 16'h0014)
		else $error("wrong vector");
	cover property (ext_irq_request);
	cover property (ext_irq_vector_valid);
	cover property (pin_oe[1] && !pin_direction[1]);
	cover property (ext_irq_pending_flag && !ext_irq_request);
endmodule
bind pbx_port_b pbx_chk u_chk(.*);

// >>> testbench/pbx_tmr.sv
`timescale 1ns/1ps
module pbx_tmr(
	input wire logic ref_clk,
	output logic     tbc_128hz,
	output logic     tbc_4khz,
	output logic     timer0_overflow_flag,
	output logic     timer1_overflow_flag
);
	// time base runs free; taps scaled down to keep the run short
	logic [6:0] cnt_q = 7'h00;
	always_ff @(posedge ref_clk) cnt_q <= cnt_q + 7'h01;
	assign tbc_4khz = cnt_q[2];
	assign tbc_128hz = cnt_q[5];
	assign timer0_overflow_flag = cnt_q[3];
	assign timer1_overflow_flag = cnt_q[4];
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import pbx_pkg::*;
	logic ref_clk = 1'h0, resetn = 1'h0, reg_write = 1'h0, reg_read = 1'h0, ext_irq_accept = 1'h0, pend = 1'h0;
	logic tbc_128hz, tbc_4khz, timer0_overflow_flag, timer1_overflow_flag, timer0_capture_in, timer1_capture_in;
	logic timer0_2_ext_clock, timer1_3_ext_clock, ext_irq_request, ext_irq_pending_flag, ext_irq_vector_valid, irq;
	logic [7:0] reg_addr = 8'h00, lf = 8'h42;
	logic [3:0] reg_wdata = 4'h0, pin_in = 4'hC, pin_input_idle_high = 4'hC, pin_direction = 4'h0;
	logic [3:0] port_data_out = 4'h0, reg_rdata, pin_out, pin_oe;
	logic [15:0] ext_irq_vector;
	logic [3:0] expq[$];
	int num_errors = 0, checks = 0;
	pbx_port_b DUT(.*);
	pbx_tmr u_tmr(.*);
	// ----------------
	// helpers
	// ----------------
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		pin_direction <= lf[3:0];
		port_data_out <= lf[7:4];
	end
	task automatic cmp(input string n, input logic [3:0] s, input logic [3:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask
	always @(posedge ref_clk) begin
		if (pend) cmp("rdata", reg_rdata, expq.pop_front());
		pend <= reg_read;
	end
	// gap cycle after each strobe so a strobe is never assigned twice at one edge
	task automatic wr(input logic [7:0] a, input logic [3:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge ref_clk);
		reg_write <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [3:0] e);
		expq.push_back(e);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge ref_clk);
		reg_read <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic wreq(input int n, input logic e);
		logic got;
		got = 1'h0;
		repeat (n) begin
			@(posedge ref_clk);
			if (ext_irq_request === 1'h1) got = 1'h1;
		end
		cmp("request", {3'h0, got}, {3'h0, e});
	endtask
	task automatic tally_and_finish;
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		tally_and_finish;
	end
	// ----------------
	// scenarios
	// ----------------
	initial begin
		repeat (4) @(posedge ref_clk);
		resetn <= 1'h1;
		@(posedge ref_clk);
		rd(8'h31, 4'h0);
		rd(8'h32, 4'h0);
		rd(8'h40, 4'h0);
		wr(8'h32, 4'hF);
		rd(8'h32, 4'hB);
		repeat (40) @(posedge ref_clk);
		wr(8'h32, 4'h0);
		wr(8'h31, 4'hF);
		rd(8'h31, 4'hF);
		wr(8'h3D, 4'h1);
		pin_in <= 4'hD;
		wreq(66, 1'h1);
		cmp("irq", {3'h0, irq}, 4'h1);
		rd(8'h3C, 4'h1);
		ext_irq_accept <= 1'h1;
		@(posedge ref_clk);
		ext_irq_accept <= 1'h0;
		@(posedge ref_clk);
		cmp("pending", {3'h0, ext_irq_pending_flag}, 4'h0);
		wr(8'h3C, 4'h1);
		cmp("irq", {3'h0, irq}, 4'h0);
		pin_in <= 4'hC;
		wreq(66, 1'h1);
		rd(8'h3E, 4'hC);
		wr(8'h31, 4'hE);
		pin_in <= 4'hD;
		wreq(130, 1'h0);
		pin_in <= 4'hC;
		wr(8'h32, 4'h8);
		pin_in <= 4'h4;
		wreq(10, 1'h1);
		tally_and_finish;
	end
endmodule
